// >>> src/rtcal_pkg.sv
/*
 Package for the alarm compare and tick trim block: register map, fields, reset values and timing.
 Assumes a 200 MHz system clock and a 32.768 kHz tick pin sampled into that domain.
*/
package rtcal_pkg;

	// ==========================================
	// Register byte addresses (index times four)
	localparam logic [7:0] RTCAL_IDX_ALM_SM    = 8'h14;
	localparam logic [7:0] RTCAL_IDX_ALM_HW    = 8'h15;
	localparam logic [7:0] RTCAL_IDX_ALM_MD    = 8'h16;
	localparam logic [7:0] RTCAL_IDX_TCTRL     = 8'h17;
	localparam logic [7:0] RTCAL_IDX_TRIM      = 8'h18;
	localparam logic [7:0] RTCAL_IDX_STATUS    = 8'h19;
	localparam logic [7:0] RTCAL_ADDR_ALM_SM   = 8'h50;
	localparam logic [7:0] RTCAL_ADDR_ALM_HW   = 8'h54;
	localparam logic [7:0] RTCAL_ADDR_ALM_MD   = 8'h58;
	localparam logic [7:0] RTCAL_ADDR_TCTRL    = 8'h5C;
	localparam logic [7:0] RTCAL_ADDR_TRIM     = 8'h60;
	localparam logic [7:0] RTCAL_ADDR_STATUS   = 8'h64;

	// ==========================================
	// Control and status register bit positions
	localparam int RTCAL_BIT_BCD       = 15;
	localparam int RTCAL_BIT_12HR      = 14;
	localparam int RTCAL_BIT_TICK_ENA  = 11;
	localparam int RTCAL_BIT_ALM_STOP  = 9;
	localparam int RTCAL_BIT_ALM_STS   = 8;
	localparam int RTCAL_BIT_TICK_STS  = 0;
	localparam int RTCAL_BIT_ALM_FLAG  = 1;

	// ==========================================
	// Reset values
	localparam logic [15:0] RTCAL_RST_ALARM = 16'h0000;
	localparam logic [9:0]  RTCAL_RST_TRIM  = 10'h000;
	localparam logic        RTCAL_RST_TENA  = 1'b1;

	// ==========================================
	// Tick timing: 32768 crystal cycles per second, trim in 1/64 Hz
	localparam logic [14:0] RTCAL_TICK_NOM    = 15'h7FFF;
	localparam int          RTCAL_TRIM_FRAC   = 6;

	// ==========================================
	// Current time from the counters
	typedef struct packed {
		logic [6:0] seconds;
		logic [6:0] minutes;
		logic [4:0] hours;
		logic       pm;
		logic [3:0] weekday;
		logic [5:0] monthday;
		logic [4:0] month;
	} rtcal_time_t;

	// Alarm fields
	typedef struct packed {
		logic [6:0] alarm_seconds_field;
		logic [6:0] alarm_minutes_field;
		logic [4:0] alarm_hours_field;
		logic       alarm_pm_flag;
		logic [3:0] alarm_weekday_field;
		logic [4:0] alarm_month_field;
		logic [5:0] alarm_monthday_field;
	} rtcal_alarm_t;

	typedef enum logic [1:0] {RTCAL_TK_RUN, RTCAL_TK_DRAIN, RTCAL_TK_HELD} rtcal_tick_st_t;

endpackage

// >>> src/rtcal_top.sv
/*
 Alarm compare and one-second tick trim control with an AXI4-Lite register slave.
 Assumes the time counters live outside, present the current time and pulse an update strobe.
*/
// Summary of operation
// RULE_01 - Alarm seconds in first register bits 6:0
// RULE_02 - Alarm minutes in first register bits 14:8
// RULE_03 - Alarm hours in second register bits 4:0
// RULE_04 - PM flag bit 5 compared in 12-hour; the code skips it when the alarm hours field is all ones
// RULE_05 - Software sets PM flag per wildcard hours
// RULE_06 - Alarm weekday in second register bits 11:8
// RULE_07 - Alarm month in third register bits 12:8
// RULE_08 - Alarm date in third register bits 5:0
// RULE_09 - All-ones field matches any value
// RULE_10 - Alarm active while remaining fields match
// RULE_11 - Control bit 9 requests alarm stop
// RULE_12 - Control bit 8 reports alarm actually stopped
// RULE_13 - Software stops, polls, writes, then releases
// RULE_14 - Software stops alarm before reprogramming fields
// RULE_15 - Trim corrects crystal error up to 8Hz
// RULE_16 - Tick disable stops generator, then status set
// RULE_17 - Software disables tick, polls, trims, enables
// RULE_18 - Full match raises alarm event flag
// RULE_19 - Control bit 14 selects 12-hour mode
// RULE_20 - Control bit 15 selects BCD coding
// RULE_21 - Compare after updates, suppressed when stopped
module rtcal_top
	import rtcal_pkg::*;
(
	// Clock and reset
	input  wire logic                   CLOCK,
	input  wire logic                   RST_B,
	// AXI4-Lite slave
	input  wire logic [7:0]             S_AXI_AWADDR,
	input  wire logic                   S_AXI_AWVALID,
	output logic                        S_AXI_AWREADY,
	input  wire logic [31:0]            S_AXI_WDATA,
	input  wire logic [3:0]             S_AXI_WSTRB,
	input  wire logic                   S_AXI_WVALID,
	output logic                        S_AXI_WREADY,
	output logic [1:0]                  S_AXI_BRESP,
	output logic                        S_AXI_BVALID,
	input  wire logic                   S_AXI_BREADY,
	input  wire logic [7:0]             S_AXI_ARADDR,
	input  wire logic                   S_AXI_ARVALID,
	output logic                        S_AXI_ARREADY,
	output logic [31:0]                 S_AXI_RDATA,
	output logic [1:0]                  S_AXI_RRESP,
	output logic                        S_AXI_RVALID,
	input  wire logic                   S_AXI_RREADY,
	// Time counters
	input  wire rtcal_pkg::rtcal_time_t TIME_NOW,
	input  wire logic                   TIME_UPDATE,
	// Crystal clock pin
	input  wire logic                   XTAL_32K,
	// Results
	output logic                        SECOND_TICK,
	output logic                        ALARM_ACTIVE,
	output logic                        ALARM_EVENT,
	output logic                        BCD_MODE,
	output logic                        TWELVE_HOUR
);
	import rtcal_pkg::*;

	// ==========================================
	// Registers
	rtcal_alarm_t   alarm_q;
	logic [15:0]    tctrl_q;
	logic [9:0]     trim_q;
	logic           alarm_stop_request_q;
	logic           alarm_stopped_status_q;
	logic           tick_generator_enable_q;
	logic           tick_request_status_q;
	logic           alarm_event_flag_q;
	logic           alarm_match_q;
	logic           aw_hold_q;
	logic           w_hold_q;
	logic [7:0]     awaddr_q;
	logic [31:0]    wdata_q;
	logic [3:0]     wstrb_q;

	// ==========================================
	// Write channel: address and data taken in either order
	wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
	wire w_take  = S_AXI_WVALID && S_AXI_WREADY;
	wire wr_go   = aw_hold_q && w_hold_q && !S_AXI_BVALID;
	wire [15:0] wr_lo = {wstrb_q[1] ? wdata_q[15:8] : 8'h00, wstrb_q[0] ? wdata_q[7:0] : 8'h00};
	wire [15:0] wr_mask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	wire sel_sm   = awaddr_q == RTCAL_ADDR_ALM_SM;
	wire sel_hw   = awaddr_q == RTCAL_ADDR_ALM_HW;
	wire sel_md   = awaddr_q == RTCAL_ADDR_ALM_MD;
	wire sel_tc   = awaddr_q == RTCAL_ADDR_TCTRL;
	wire sel_tr   = awaddr_q == RTCAL_ADDR_TRIM;
	wire sel_st   = awaddr_q == RTCAL_ADDR_STATUS;
	wire wr_hit   = sel_sm || sel_hw || sel_md || sel_tc || sel_tr || sel_st;

	wire [15:0] cur_sm = {1'b0, alarm_q.alarm_minutes_field, 1'b0, alarm_q.alarm_seconds_field};
	wire [15:0] cur_hw = {4'h0, alarm_q.alarm_weekday_field, 2'b00, alarm_q.alarm_pm_flag,
		alarm_q.alarm_hours_field};
	wire [15:0] cur_md = {3'b000, alarm_q.alarm_month_field, 2'b00, alarm_q.alarm_monthday_field};
	wire [15:0] new_sm = (cur_sm & ~wr_mask) | (wr_lo & wr_mask);
	wire [15:0] new_hw = (cur_hw & ~wr_mask) | (wr_lo & wr_mask);
	wire [15:0] new_md = (cur_md & ~wr_mask) | (wr_lo & wr_mask);
	wire [15:0] new_tc = (tctrl_q & ~wr_mask) | (wr_lo & wr_mask);
	wire [15:0] new_tr = ({6'h00, trim_q} & ~wr_mask) | (wr_lo & wr_mask);

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			aw_hold_q    <= 1'b0;
			w_hold_q     <= 1'b0;
			awaddr_q     <= 8'h00;
			wdata_q      <= 32'h0000_0000;
			wstrb_q      <= 4'h0;
			S_AXI_BVALID  <= 1'b0;
			S_AXI_BRESP   <= 2'b00;
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY  <= 1'b1;
		end else begin
			// Readies mirror !hold && !bvalid, kept in flops
			if (aw_take) begin
				aw_hold_q     <= 1'b1;
				awaddr_q      <= S_AXI_AWADDR;
				S_AXI_AWREADY <= 1'b0;
			end
			if (w_take) begin
				S_AXI_WREADY <= 1'b0;
				w_hold_q <= 1'b1;
				wdata_q  <= S_AXI_WDATA;
				wstrb_q  <= S_AXI_WSTRB;
			end
			if (wr_go) begin
				aw_hold_q    <= 1'b0;
				w_hold_q     <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= wr_hit ? 2'b00 : 2'b10;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID  <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY  <= 1'b1;
			end
		end
	end

	// ==========================================
	// Alarm and control registers
	wire flag_clr = wr_go && sel_st && wstrb_q[0] && wdata_q[RTCAL_BIT_ALM_FLAG];

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			alarm_q                 <= rtcal_alarm_t'(35'(RTCAL_RST_ALARM));
			tctrl_q                 <= 16'h0000;
			trim_q                  <= RTCAL_RST_TRIM;
			alarm_stop_request_q    <= 1'b0;
			tick_generator_enable_q <= RTCAL_RST_TENA;
		end else if (wr_go) begin
			if (sel_sm) begin
				alarm_q.alarm_seconds_field <= new_sm[6:0]; // RULE_01
				alarm_q.alarm_minutes_field <= new_sm[14:8]; // RULE_02
			end
			if (sel_hw) begin
				alarm_q.alarm_hours_field   <= new_hw[4:0]; // RULE_03
				alarm_q.alarm_pm_flag       <= new_hw[5]; // RULE_04
				alarm_q.alarm_weekday_field <= new_hw[11:8]; // RULE_06
			end
			if (sel_md) begin
				alarm_q.alarm_month_field    <= new_md[12:8]; // RULE_07
				alarm_q.alarm_monthday_field <= new_md[5:0]; // RULE_08
			end
			if (sel_tc) begin
				tctrl_q                 <= new_tc & 16'hC000; // RULE_19 RULE_20
				alarm_stop_request_q    <= new_tc[RTCAL_BIT_ALM_STOP]; // RULE_11
				tick_generator_enable_q <= new_tc[RTCAL_BIT_TICK_ENA];
			end
			if (sel_tr && !tick_generator_enable_q && tick_request_status_q) begin
				trim_q <= new_tr[9:0];
			end
		end
	end

	// ==========================================
	// Alarm compare
	function automatic logic rtcal_fld(input logic [6:0] alm, input logic [6:0] now, input logic [6:0] ones);
		rtcal_fld = (alm == ones) || (alm == now); // RULE_09
	endfunction

	wire twelve_hour_select = tctrl_q[RTCAL_BIT_12HR];
	wire hrs_wild = alarm_q.alarm_hours_field == 5'h1F;
	wire pm_ok = !twelve_hour_select || hrs_wild || (alarm_q.alarm_pm_flag == TIME_NOW.pm); // RULE_04
	wire full_match =
		rtcal_fld(alarm_q.alarm_seconds_field, TIME_NOW.seconds, 7'h7F) &&
		rtcal_fld(alarm_q.alarm_minutes_field, TIME_NOW.minutes, 7'h7F) &&
		rtcal_fld({2'b00, alarm_q.alarm_hours_field}, {2'b00, TIME_NOW.hours}, 7'h1F) && pm_ok &&
		rtcal_fld({3'b000, alarm_q.alarm_weekday_field}, {3'b000, TIME_NOW.weekday}, 7'h0F) &&
		rtcal_fld({1'b0, alarm_q.alarm_monthday_field}, {1'b0, TIME_NOW.monthday}, 7'h3F) &&
		rtcal_fld({2'b00, alarm_q.alarm_month_field}, {2'b00, TIME_NOW.month}, 7'h1F);

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			alarm_stopped_status_q <= 1'b0;
			alarm_match_q          <= 1'b0;
			alarm_event_flag_q     <= 1'b0;
		end else begin
			// Stop takes effect only once no compare is in flight
			if (!TIME_UPDATE) begin
				alarm_stopped_status_q <= alarm_stop_request_q; // RULE_12
			end
			if (alarm_stopped_status_q) begin
				alarm_match_q <= 1'b0; // RULE_21
			end else if (TIME_UPDATE) begin
				alarm_match_q <= full_match; // RULE_10 RULE_21
			end
			if (TIME_UPDATE && !alarm_stopped_status_q && full_match && !alarm_match_q) begin
				alarm_event_flag_q <= 1'b1; // RULE_18
			end else if (flag_clr) begin
				alarm_event_flag_q <= 1'b0;
			end
		end
	end

	// ==========================================
	// One-second tick generator with trim
	logic [2:0]      xtal_sync_q;
	logic [15:0]     tick_cnt_q;
	logic [16:0]     frac_acc_q;
	logic            second_tick_q;
	rtcal_tick_st_t  tick_st_q;

	wire xtal_rise = xtal_sync_q[1] && !xtal_sync_q[2];
	// Accumulated trim in 1/64 Hz over one second gives whole crystal cycles to add
	wire signed [16:0] acc_next = $signed(frac_acc_q) + $signed({{7{trim_q[9]}}, trim_q});
	wire signed [10:0] extra = 11'(acc_next >>> RTCAL_TRIM_FRAC);
	wire [15:0] target = 16'({1'b0, RTCAL_TICK_NOM}) + 16'({{5{extra[10]}}, extra}); // RULE_15
	// Counter one bit wider than nominal so a trimmed-up second still ends
	wire sec_done = xtal_rise && (tick_cnt_q >= target);

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			xtal_sync_q           <= 3'b000;
			tick_cnt_q            <= 16'h0000;
			frac_acc_q            <= 17'h00000;
			second_tick_q         <= 1'b0;
			tick_st_q             <= RTCAL_TK_RUN;
			tick_request_status_q <= 1'b0;
		end else begin
			xtal_sync_q   <= {xtal_sync_q[1:0], XTAL_32K};
			second_tick_q <= 1'b0;
			unique case (tick_st_q)
				RTCAL_TK_RUN: begin
					if (!tick_generator_enable_q) begin
						tick_st_q <= RTCAL_TK_DRAIN; // RULE_16
					end else if (sec_done) begin
						tick_cnt_q    <= 16'h0000;
						frac_acc_q    <= 17'(acc_next - ($signed(extra) <<< RTCAL_TRIM_FRAC));
						second_tick_q <= 1'b1;
					end else if (xtal_rise) begin
						tick_cnt_q <= tick_cnt_q + 16'h0001;
					end
				end
				RTCAL_TK_DRAIN: begin
					tick_st_q             <= RTCAL_TK_HELD;
					tick_request_status_q <= 1'b1; // RULE_16
				end
				RTCAL_TK_HELD: begin
					if (tick_generator_enable_q) begin
						tick_st_q             <= RTCAL_TK_RUN;
						tick_request_status_q <= 1'b0;
						tick_cnt_q            <= 16'h0000;
						frac_acc_q            <= 17'h00000;
					end
				end
			endcase
		end
	end

	// ==========================================
	// Read channel
	logic [31:0] rd_mux;
	wire [15:0] rd_tc = tctrl_q | (16'(tick_generator_enable_q) << RTCAL_BIT_TICK_ENA) |
		(16'(alarm_stop_request_q) << RTCAL_BIT_ALM_STOP) |
		(16'(alarm_stopped_status_q) << RTCAL_BIT_ALM_STS);
	wire [15:0] rd_st = {14'h0000, alarm_event_flag_q, tick_request_status_q};
	wire        rd_hit = S_AXI_ARADDR inside {RTCAL_ADDR_ALM_SM, RTCAL_ADDR_ALM_HW, RTCAL_ADDR_ALM_MD,
		RTCAL_ADDR_TCTRL, RTCAL_ADDR_TRIM, RTCAL_ADDR_STATUS};

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (S_AXI_ARADDR)
			RTCAL_ADDR_ALM_SM: rd_mux = {16'h0000, cur_sm};
			RTCAL_ADDR_ALM_HW: rd_mux = {16'h0000, cur_hw};
			RTCAL_ADDR_ALM_MD: rd_mux = {16'h0000, cur_md};
			RTCAL_ADDR_TCTRL:  rd_mux = {16'h0000, rd_tc};
			RTCAL_ADDR_TRIM:   rd_mux = {22'h000000, trim_q};
			RTCAL_ADDR_STATUS: rd_mux = {16'h0000, rd_st};
			default:           rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			S_AXI_RVALID  <= 1'b0;
			S_AXI_RDATA   <= 32'h0000_0000;
			S_AXI_RRESP   <= 2'b00;
			S_AXI_ARREADY <= 1'b1;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA  <= rd_mux;
			S_AXI_RRESP  <= rd_hit ? 2'b00 : 2'b10;
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			S_AXI_RVALID  <= 1'b0;
			S_AXI_ARREADY <= 1'b1;
		end
	end

	// ==========================================
	// Outputs
	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			SECOND_TICK  <= 1'b0;
			ALARM_ACTIVE <= 1'b0;
			ALARM_EVENT  <= 1'b0;
			BCD_MODE     <= 1'b0;
			TWELVE_HOUR  <= 1'b0;
		end else begin
			SECOND_TICK  <= second_tick_q;
			ALARM_ACTIVE <= alarm_match_q;
			ALARM_EVENT  <= alarm_event_flag_q;
			BCD_MODE     <= tctrl_q[RTCAL_BIT_BCD];
			TWELVE_HOUR  <= twelve_hour_select;
		end
	end

endmodule // rtcal_top

// >>> tb/rtcal_properties.sv
/*
 Port checker for the alarm compare and tick trim block.
 Assumes it is bound to rtcal_top and sees one clock domain.
*/
module rtcal_props (
	// Clock and reset
	input wire logic        CLOCK,
	input wire logic        RST_B,
	// Register bus
	input wire logic        S_AXI_AWREADY,
	input wire logic        S_AXI_BVALID,
	input wire logic        S_AXI_BREADY,
	input wire logic        S_AXI_ARREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic        S_AXI_RVALID,
	input wire logic        S_AXI_RREADY,
	// Alarm, tick and mode
	input wire logic        TIME_UPDATE,
	input wire logic        SECOND_TICK,
	input wire logic        ALARM_ACTIVE,
	input wire logic        ALARM_EVENT,
	input wire logic        BCD_MODE,
	input wire logic        TWELVE_HOUR
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_B);

	// ==========================================
	// Bus handshakes
	a_bvalid_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID) else $error("bvalid dropped");
	a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read answer not held");
	a_arready_idle: assert property (S_AXI_ARREADY == !S_AXI_RVALID) else $error("arready wrong");
	a_aw_blocked: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY) else $error("aw taken during response");

	// ==========================================
	// Alarm, mode and tick behaviour
	a_event_on_rise: assert property (
		$rose(ALARM_ACTIVE) |-> ##[0:2] ALARM_EVENT) else $error("event flag not raised");
	a_active_cause: assert property (
		$rose(ALARM_ACTIVE) |-> $past(TIME_UPDATE) || $past(TIME_UPDATE, 2)) else $error("alarm without update");
	a_active_hold: assert property (
		$fell(ALARM_ACTIVE) |-> $past(TIME_UPDATE) || $past(TIME_UPDATE, 2) || S_AXI_BVALID || $past(S_AXI_BVALID)
		|| $past(S_AXI_BVALID, 2) || $past(S_AXI_BVALID, 3)) else $error("alarm dropped without cause");
	a_event_clear: assert property (
		$fell(ALARM_EVENT) |-> S_AXI_BVALID || $past(S_AXI_BVALID) || $past(S_AXI_BVALID, 2))
		else $error("event flag lost");
	a_hour_mode: assert property (
		!$stable(TWELVE_HOUR) |-> S_AXI_BVALID || $past(S_AXI_BVALID) || $past(S_AXI_BVALID, 2))
		else $error("hour mode moved alone");
	a_bcd_mode: assert property (
		!$stable(BCD_MODE) |-> S_AXI_BVALID || $past(S_AXI_BVALID) || $past(S_AXI_BVALID, 2))
		else $error("coding mode moved alone");
	a_tick_pulse: assert property (SECOND_TICK |=> !SECOND_TICK) else $error("tick longer than a cycle");
endmodule // rtcal_props

// >>> tb/tb_rtcal_top.sv
/*
 Self-checking bench for the alarm compare and tick trim block.
 Assumes the register map and timing of rtcal_pkg and an AXI4-Lite master here.
*/
module tb_rtcal_top;
	timeunit 1ns;
	timeprecision 1ps;
	import rtcal_pkg::*;
	logic        clock = 1'b0, rst_b = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0, tupd = 1'b0, xtal = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic [15:0] mode = 16'h0800;
	rtcal_time_t  tnow = '0;
	rtcal_time_t  mt = '{7'h05, 7'h10, 5'h03, 1'b0, 4'h2, 6'h09, 5'h04};
	rtcal_alarm_t ba = '{7'h05, 7'h10, 5'h03, 1'b0, 4'h2, 5'h04, 6'h09};
	wire logic        awready, wready, bvalid, arready, rvalid, tick, active, evt, bcd, twelve;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	int fails = 0;
	int tests_run = 0;

	rtcal_top dut_u (.CLOCK(clock), .RST_B(rst_b), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h3), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .TIME_NOW(tnow), .TIME_UPDATE(tupd),
		.XTAL_32K(xtal), .SECOND_TICK(tick), .ALARM_ACTIVE(active), .ALARM_EVENT(evt), .BCD_MODE(bcd),
		.TWELVE_HOUR(twelve));

	// ==========================================
	// Clock, crystal and watchdog
	initial forever #2.5 clock = ~clock;
	initial forever begin
		repeat (3) @(posedge clock);
		xtal <= ~xtal;
	end
	initial begin
		repeat (40000) @(posedge clock);
		fails++;
		wrap_up;
	end

	// ==========================================
	// Helpers
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= {16'h0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clock);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 200);
		bready <= 1'b0;
		chk(bresp, er);
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clock);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 200);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(d, e);
		chk(r, er);
	endtask
	task automatic poll(input logic [7:0] a, input int b, input logic v);
		logic [31:0] d;
		logic [1:0]  r;
		int          n;
		n = 0;
		do begin
			rd(a, d, r);
			n++;
		end while (d[b] !== v && n < 50);
		chk(d[b], v);
	endtask
	task automatic set_alarm(input rtcal_alarm_t al);
		wr(RTCAL_ADDR_TCTRL, mode | 16'h0200, 2'b00);
		poll(RTCAL_ADDR_TCTRL, RTCAL_BIT_ALM_STS, 1'b1);
		wr(RTCAL_ADDR_ALM_SM, {1'b0, al.alarm_minutes_field, 1'b0, al.alarm_seconds_field}, 2'b00);
		wr(RTCAL_ADDR_ALM_HW, {4'h0, al.alarm_weekday_field, 2'b00, al.alarm_pm_flag, al.alarm_hours_field}, 2'b00);
		wr(RTCAL_ADDR_ALM_MD, {3'h0, al.alarm_month_field, 2'b00, al.alarm_monthday_field}, 2'b00);
		wr(RTCAL_ADDR_TCTRL, mode, 2'b00);
		poll(RTCAL_ADDR_TCTRL, RTCAL_BIT_ALM_STS, 1'b0);
	endtask
	task automatic step(input rtcal_time_t t, input logic ea);
		tnow <= t;
		tupd <= 1'b1;
		@(posedge clock);
		tupd <= 1'b0;
		repeat (4) @(posedge clock);
		chk(active, ea);
	endtask

	// ==========================================
	// Scenarios
	task automatic t_reset;
		rchk(RTCAL_ADDR_ALM_SM, 32'h00000000, 2'b00);
		rchk(RTCAL_ADDR_ALM_HW, 32'h00000000, 2'b00);
		rchk(RTCAL_ADDR_ALM_MD, 32'h00000000, 2'b00);
		rchk(RTCAL_ADDR_TCTRL, 32'h00000800, 2'b00);
		chk({active, evt, tick, bcd, twelve}, 5'h00);
		$display("t_reset done");
	endtask
	task automatic t_regs;
		wr(RTCAL_ADDR_ALM_SM, 16'hFFFF, 2'b00);
		rchk(RTCAL_ADDR_ALM_SM, 32'h00007F7F, 2'b00);
		wr(RTCAL_ADDR_ALM_HW, 16'hFFFF, 2'b00);
		rchk(RTCAL_ADDR_ALM_HW, 32'h00000F3F, 2'b00);
		wr(RTCAL_ADDR_ALM_MD, 16'hFFFF, 2'b00);
		rchk(RTCAL_ADDR_ALM_MD, 32'h00001F3F, 2'b00);
		wr(8'h70, 16'h1234, 2'b10);
		rchk(8'h70, 32'h00000000, 2'b10);
		$display("t_regs done");
	endtask
	task automatic t_match;
		rtcal_time_t t;
		set_alarm(ba);
		step(mt, 1'b1);
		chk(evt, 1'b1);
		t = mt;
		t.seconds = 7'h06;
		step(t, 1'b0);
		chk(evt, 1'b1);
		wr(RTCAL_ADDR_STATUS, 16'h0002, 2'b00);
		repeat (2) @(posedge clock);
		chk(evt, 1'b0);
		$display("t_match done");
	endtask
	task automatic t_wild;
		int ap[6] = '{28, 21, 16, 11, 0, 6};
		int aw[6] = '{7, 7, 5, 4, 6, 5};
		int tp[6] = '{28, 21, 16, 11, 5, 0};
		rtcal_alarm_t al;
		rtcal_time_t  t;
		set_alarm(ba);
		for (int i = 0; i < 6; i++) begin
			t = rtcal_time_t'(mt ^ (35'h1 << tp[i]));
			step(t, 1'b0);
		end
		for (int i = 0; i < 6; i++) begin
			al = rtcal_alarm_t'(ba | (((35'h1 << aw[i]) - 35'h1) << ap[i]));
			if (i == 2) al.alarm_pm_flag = 1'b1;
			t = rtcal_time_t'(mt ^ (35'h1 << tp[i]));
			set_alarm(al);
			step(t, 1'b1);
		end
		al = ba;
		al.alarm_seconds_field = 7'h7F;
		set_alarm(al);
		t = mt;
		for (int s = 0; s < 60; s += 20) begin
			t.seconds = 7'(s);
			step(t, 1'b1);
		end
		t.minutes = 7'h11;
		step(t, 1'b0);
		$display("t_wild done");
	endtask
	task automatic t_twelve;
		rtcal_alarm_t al;
		rtcal_time_t  t;
		mode = 16'hC800;
		wr(RTCAL_ADDR_TCTRL, mode, 2'b00);
		repeat (2) @(posedge clock);
		chk({bcd, twelve}, 2'b11);
		al = ba;
		al.alarm_hours_field = 5'h07;
		al.alarm_pm_flag = 1'b1;
		set_alarm(al);
		t = mt;
		t.hours = 5'h07;
		step(t, 1'b0);
		t.pm = 1'b1;
		step(t, 1'b1);
		mode = 16'h0800;
		wr(RTCAL_ADDR_TCTRL, mode, 2'b00);
		al.alarm_pm_flag = 1'b0;
		set_alarm(al);
		step(t, 1'b1);
		chk({bcd, twelve}, 2'b00);
		$display("t_twelve done");
	endtask
	task automatic t_stop;
		set_alarm(ba);
		step(rtcal_time_t'(mt ^ 35'h1), 1'b0);
		wr(RTCAL_ADDR_TCTRL, mode | 16'h0200, 2'b00);
		poll(RTCAL_ADDR_TCTRL, RTCAL_BIT_ALM_STS, 1'b1);
		step(mt, 1'b0);
		wr(RTCAL_ADDR_TCTRL, mode, 2'b00);
		poll(RTCAL_ADDR_TCTRL, RTCAL_BIT_ALM_STS, 1'b0);
		step(mt, 1'b1);
		$display("t_stop done");
	endtask
	task automatic t_tick;
		wr(RTCAL_ADDR_TRIM, 16'h0155, 2'b00);
		rchk(RTCAL_ADDR_TRIM, 32'h00000000, 2'b00);
		mode = 16'h0000;
		wr(RTCAL_ADDR_TCTRL, mode, 2'b00);
		poll(RTCAL_ADDR_STATUS, RTCAL_BIT_TICK_STS, 1'b1);
		wr(RTCAL_ADDR_TRIM, 16'h03F0, 2'b00);
		rchk(RTCAL_ADDR_TRIM, 32'h000003F0, 2'b00);
		mode = 16'h0800;
		wr(RTCAL_ADDR_TCTRL, mode, 2'b00);
		poll(RTCAL_ADDR_STATUS, RTCAL_BIT_TICK_STS, 1'b0);
		$display("t_tick done");
	endtask

	task automatic wrap_up;
		$display("tests_run=%0d fails=%0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		t_reset;
		t_regs;
		t_match;
		t_wild;
		t_twelve;
		t_stop;
		t_tick;
		wrap_up;
	end
endmodule // tb_rtcal_top

bind rtcal_top rtcal_props chk_u (.CLOCK, .RST_B, .S_AXI_AWREADY, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARREADY,
	.S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .TIME_UPDATE, .SECOND_TICK, .ALARM_ACTIVE, .ALARM_EVENT,
	.BCD_MODE, .TWELVE_HOUR);
